// file: src/fpx_fma_div.sv
// single rounding datapath: a*b+c exact, or a/b, rounded once to nearest even
module fpx_fma_div
    import fpx_pkg::*;
(
    input  wire logic [31:0] opA,
    input  wire logic [31:0] opB,
    input  wire logic [31:0] opC,
    input  wire logic        isDiv,
    output logic      [31:0] result
);
    logic               zA, zB, sP, sBig, sgn, special, remNz, pBig;
    logic        [23:0] mA, mB, mC;
    logic        [47:0] prod;
    logic        [26:0] quo;
    logic signed [11:0] eP, eC, eBig, eSml, d, eRes;
    logic        [52:0] mPw, mCw, mBig, mSml, sml, sum, nrm;
    logic        [5:0]  p;
    logic        [24:0] rnd;

    // unpack; subnormals are flushed to zero to keep the aligner small
    assign zA   = opA[30:23] == 8'h00;
    assign zB   = opB[30:23] == 8'h00;
    assign mA   = zA ? 24'h0 : {1'b1, opA[22:0]};
    assign mB   = zB ? 24'h0 : {1'b1, opB[22:0]};
    assign mC   = (opC[30:23] == 8'h00) ? 24'h0 : {1'b1, opC[22:0]};
    assign sP   = opA[31] ^ opB[31];
    assign prod = mA * mB;
    assign quo  = 27'({mA, 26'h0} / {26'h0, mB});
    assign remNz = zB ? 1'b0 : (({mA, 26'h0} % {26'h0, mB}) != 50'h0);
    assign special = opA[30:23] == EXP_MAX || opB[30:23] == EXP_MAX
                     || (!isDiv && opC[30:23] == EXP_MAX);

    // align the smaller term with sticky, add, normalise, round once
    always_comb begin
        eP   = isDiv ? 12'($signed({4'h0, opA[30:23]}) - $signed({4'h0, opB[30:23]}) + 12'sd150)
                     : 12'($signed({4'h0, opA[30:23]}) + $signed({4'h0, opB[30:23]}) - 12'sd126);
        eC   = $signed({4'h0, opC[30:23]});
        mPw  = isDiv ? {25'h0, quo, remNz} : {2'b0, prod, 3'b0};
        mCw  = isDiv ? 53'h0 : {2'b0, mC, 24'h0, 3'b0};
        pBig = (mCw == 53'h0) || (mPw != 53'h0 && eP >= eC);
        eBig = pBig ? eP : eC;
        eSml = pBig ? eC : eP;
        mBig = pBig ? mPw : mCw;
        mSml = pBig ? mCw : mPw;
        sBig = pBig ? sP : opC[31];
        d    = eBig - eSml;
        if (d > 12'sd52) begin
            sml = {52'h0, |mSml};
        end else begin
            sml = (mSml >> d) | {52'h0, |(mSml & ~({53{1'b1}} << d))};
        end
        sgn = sBig;
        if (sBig == (pBig ? opC[31] : sP)) begin
            sum = mBig + sml;
        end else if (mBig >= sml) begin
            sum = mBig - sml;
        end else begin
            sum = sml - mBig;
            sgn = ~sBig;
        end
        p = 6'h0;
        for (int i = 0; i < 53; i++) begin
            if (sum[i]) begin
                p = 6'(i);
            end
        end
        nrm  = sum << (6'd52 - p);
        rnd  = {1'b0, nrm[52:29]} + 25'(nrm[28] & ((|nrm[27:0]) | nrm[29]));
        eRes = eBig + $signed({6'h0, p}) - 12'sd50 + $signed({11'h0, rnd[24]});
        if (special) begin
            result = FP_QNAN;
        end else if (isDiv && zB) begin
            result = zA ? FP_QNAN : {sP, EXP_MAX, 23'h0};
        end else if (sum == 53'h0 || eRes <= 12'sd0) begin
            result = {sgn & (sum != 53'h0), 31'h0};
        end else if (eRes >= 12'sd255) begin
            result = {sgn, EXP_MAX, 23'h0};
        end else begin
            result = {sgn, eRes[7:0], rnd[24] ? 23'h0 : rnd[22:0]};
        end
    end
endmodule : fpx_fma_div

// file: src/fpx_pkg.sv
package fpx_pkg;
    // operation codes presented on the issue port
    typedef enum logic [3:0] {
        OP_FP_DIVIDE         = 4'h0,
        OP_FUSED_MUL_ACC     = 4'h1,
        OP_FUSED_MUL_SUB     = 4'h2,
        OP_FUSED_NEG_MUL_ACC = 4'h3,
        OP_FUSED_NEG_MUL_SUB = 4'h4,
        OP_CHAINED_MUL_ACC   = 4'h5,
        OP_CHAINED_MUL_SUB   = 4'h6,
        OP_FP_LOAD_MULTIPLE  = 4'h7,
        OP_FP_LOAD_SINGLE    = 4'h8,
        OP_FP_MOVE_IMMEDIATE = 4'h9
    } fpx_op_e;

    // block load addressing modes
    localparam logic MODE_INCREMENT_AFTER  = 1'b0;
    localparam logic MODE_DECREMENT_BEFORE = 1'b1;

    localparam logic [31:0] FP_ONE      = 32'h3f800000;
    localparam logic [31:0] FP_ZERO     = 32'h00000000;
    localparam logic [31:0] FP_QNAN     = 32'h7fc00000;
    localparam logic [7:0]  EXP_MAX     = 8'hff;
    localparam int          WORD_SHIFT  = 2;     // byte address = word count << 2
    localparam logic [31:0] WORD_BYTES  = 32'h00000004;
    localparam int          REG_COUNT   = 32;    // singleword extension registers
    localparam logic [31:0] RF_RESET    = 32'h00000000;
endpackage : fpx_pkg

// file: src/fpx_unit.sv
// Operation
// - divide writes first operand over second operand into destination
// - fused multiply-accumulate adds exact product into destination
// - fused forms keep product unrounded, round once after the add
// - fused multiply-subtract negates first operand, then accumulates
// - fused negated accumulate: negated product plus negated destination
// - fused negated subtract: product plus negated destination
// - chained accumulate adds product to destination value
// - chained subtract takes product away from destination value
// - block load fills consecutive registers from consecutive words
// - increment-after starts at base and walks upward
// - decrement-before ends the block just below base
// - stack pointer is accepted as base register
// - single load fills one register at base plus signed offset
// - move-immediate writes expanded constant into destination
module fpx_unit
    import fpx_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        issueValid,
    input  wire logic [3:0]  issueOp,
    input  wire logic [4:0]  destIdx,
    input  wire logic        destOmitted,
    input  wire logic [4:0]  firstIdx,
    input  wire logic [4:0]  secondIdx,
    input  wire logic [7:0]  fpImm,
    input  wire logic [31:0] baseValue,
    input  wire logic        addrMode,
    input  wire logic        writeBack,
    input  wire logic        isDouble,
    input  wire logic [5:0]  regCount,
    input  wire logic        offsetAdd,
    input  wire logic [7:0]  offsetWords,
    input  wire logic [31:0] memRdata,
    input  wire logic        memRvalid,
    input  wire logic [4:0]  rdIdx,
    output logic             issueReady,
    output logic             opDone,
    output logic             memReq,
    output logic      [31:0] memAddr,
    output logic             baseWbValid,
    output logic      [31:0] baseWbData,
    output logic      [31:0] rdData
);
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_MATH  = 4'b0010,
        S_CHAIN = 4'b0100,
        S_LOAD  = 4'b1000
    } fpx_state_e;

    fpx_state_e  state_ff, nxt_state;
    fpx_op_e     op_ff;
    logic [31:0] rf_ff [REG_COUNT];
    logic [31:0] opA_ff, opB_ff, opC_ff, prod_ff;
    logic [4:0]  dst_ff, nxt_dst;
    logic [6:0]  wordsLeft_ff, nxt_wordsLeft;
    logic [31:0] memAddr_ff, nxt_memAddr;
    logic        memReq_ff, nxt_memReq;
    logic        done_ff, nxt_done;
    logic        wbPend_ff, wbValid_ff, nxt_wbValid;
    logic [31:0] wbData_ff, rdData_ff;

    // issue decode
    logic        take, isArith, isChained, isBlock, isSingle, isMovi, lastWord;
    logic        negA, negC, negP;
    logic [4:0]  arithDst, loadDst;
    logic [6:0]  blockWords;
    logic [31:0] blockBytes, singleAddr, blockAddr, immValue;
    assign take      = issueValid && state_ff == S_IDLE;
    assign isChained = issueOp == OP_CHAINED_MUL_ACC || issueOp == OP_CHAINED_MUL_SUB;
    assign isArith   = issueOp <= OP_CHAINED_MUL_SUB;
    assign isBlock   = issueOp == OP_FP_LOAD_MULTIPLE;
    assign isSingle  = issueOp == OP_FP_LOAD_SINGLE;
    assign isMovi    = issueOp == OP_FP_MOVE_IMMEDIATE;
    // chained forms always name their destination
    assign arithDst  = (destOmitted && !isChained) ? firstIdx : destIdx;
    // a double register n is the singleword pair 2n, 2n+1
    assign loadDst   = isDouble ? 5'({destIdx[3:0], 1'b0}) : destIdx;
    // a zero count would wrap; the issuer never sends one
    assign blockWords = isDouble ? {regCount, 1'b0} : {1'b0, regCount};
    assign blockBytes = {23'h0, blockWords, 2'b0};
    // base may be any core register value, stack pointer included
    assign blockAddr  = (addrMode == MODE_DECREMENT_BEFORE)
                        ? baseValue - blockBytes
                        : baseValue;
    // offset arrives in words, so it is always a multiple of four
    assign singleAddr = offsetAdd
                        ? baseValue + {22'h0, offsetWords, 2'b0}
                        : baseValue - {22'h0, offsetWords, 2'b0};
    // eight-bit constant expands to sign, exponent and top fraction
    assign immValue   = {fpImm[7], ~fpImm[6], {5{fpImm[6]}}, fpImm[5:0], 19'h0};

    // sign steering for the fused and chained variants
    assign negA = op_ff == OP_FUSED_MUL_SUB || op_ff == OP_FUSED_NEG_MUL_ACC;
    assign negC = op_ff == OP_FUSED_NEG_MUL_ACC || op_ff == OP_FUSED_NEG_MUL_SUB;
    assign negP = op_ff == OP_CHAINED_MUL_SUB;

    // math operands: chained first pass has zero addend so the product rounds alone
    logic [31:0] mathA, mathB, mathC, mathRes;
    logic        mathDiv, chainOp;
    assign chainOp = op_ff == OP_CHAINED_MUL_ACC || op_ff == OP_CHAINED_MUL_SUB;
    assign mathA   = (state_ff == S_CHAIN) ? {prod_ff[31] ^ negP, prod_ff[30:0]}
                                           : {opA_ff[31] ^ negA, opA_ff[30:0]};
    assign mathB   = (state_ff == S_CHAIN) ? FP_ONE : opB_ff;
    assign mathC   = (state_ff == S_CHAIN) ? opC_ff
                   : chainOp ? FP_ZERO
                   : {opC_ff[31] ^ negC, opC_ff[30:0]};
    assign mathDiv = op_ff == OP_FP_DIVIDE;

    fpx_fma_div fpx_fma_div_inst (
        .opA    (mathA),
        .opB    (mathB),
        .opC    (mathC),
        .isDiv  (mathDiv),
        .result (mathRes)
    );

    // single register file write port
    logic        wrEn;
    logic [4:0]  wrAddr;
    logic [31:0] wrData;
    logic        loadBeat;
    assign loadBeat = state_ff == S_LOAD && memReq_ff && memRvalid;
    assign lastWord = wordsLeft_ff == 7'd1;
    assign wrEn   = (take && isMovi)
                  || (state_ff == S_MATH && !chainOp)
                  || state_ff == S_CHAIN
                  || loadBeat;
    assign wrAddr = (state_ff == S_IDLE) ? destIdx : dst_ff;
    assign wrData = (state_ff == S_IDLE) ? immValue
                  : (state_ff == S_LOAD) ? memRdata
                  : mathRes;

    // next-state and sequencing
    always_comb begin
        nxt_state     = state_ff;
        nxt_dst       = dst_ff;
        nxt_wordsLeft = wordsLeft_ff;
        nxt_memAddr   = memAddr_ff;
        nxt_memReq    = memReq_ff;
        nxt_done      = 1'b0;
        nxt_wbValid   = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (take && isArith) begin
                    nxt_state = S_MATH;
                    nxt_dst   = arithDst;
                end else if (take && (isBlock || isSingle)) begin
                    nxt_state     = S_LOAD;
                    nxt_dst       = loadDst;
                    nxt_wordsLeft = isBlock ? blockWords : (isDouble ? 7'd2 : 7'd1);
                    nxt_memAddr   = isBlock ? blockAddr : singleAddr;
                    nxt_memReq    = 1'b1;
                end else if (take && isMovi) begin
                    nxt_done = 1'b1;
                end
            end
            S_MATH: begin
                nxt_state = chainOp ? S_CHAIN : S_IDLE;
                nxt_done  = !chainOp;
            end
            S_CHAIN: begin
                nxt_state = S_IDLE;
                nxt_done  = 1'b1;
            end
            S_LOAD: begin
                if (loadBeat) begin
                    nxt_dst       = dst_ff + 5'd1;
                    nxt_memAddr   = memAddr_ff + WORD_BYTES;
                    nxt_wordsLeft = wordsLeft_ff - 7'd1;
                    if (lastWord) begin
                        nxt_state   = S_IDLE;
                        nxt_memReq  = 1'b0;
                        nxt_done    = 1'b1;
                        nxt_wbValid = wbPend_ff;
                    end
                end
            end
            default: begin
                nxt_state  = S_IDLE;
                nxt_memReq = 1'b0;
            end
        endcase
    end

    // control state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_ff     <= S_IDLE;
            dst_ff       <= 5'h0;
            wordsLeft_ff <= 7'h0;
            memAddr_ff   <= 32'h0;
            memReq_ff    <= 1'b0;
            done_ff      <= 1'b0;
            wbValid_ff   <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            dst_ff       <= nxt_dst;
            wordsLeft_ff <= nxt_wordsLeft;
            memAddr_ff   <= nxt_memAddr;
            memReq_ff    <= nxt_memReq;
            done_ff      <= nxt_done;
            wbValid_ff   <= nxt_wbValid;
        end
    end

    // operands captured at issue so later writes cannot disturb them
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            op_ff  <= OP_FP_DIVIDE;
            opA_ff <= RF_RESET;
            opB_ff <= RF_RESET;
            opC_ff <= RF_RESET;
        end else if (take) begin
            op_ff  <= fpx_op_e'(issueOp);
            opA_ff <= rf_ff[firstIdx];
            opB_ff <= rf_ff[secondIdx];
            opC_ff <= rf_ff[arithDst];
        end
    end

    // rounded chained product and the base writeback value
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prod_ff   <= RF_RESET;
            wbPend_ff <= 1'b0;
            wbData_ff <= 32'h0;
        end else begin
            if (state_ff == S_MATH) begin
                prod_ff <= mathRes;
            end
            if (take) begin
                wbPend_ff <= isBlock && writeBack;
                wbData_ff <= (addrMode == MODE_DECREMENT_BEFORE) ? blockAddr
                                                                : baseValue + blockBytes;
            end
        end
    end

    // register file; reset clears it so reads are never unknown
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                rf_ff[i] <= RF_RESET;
            end
            rdData_ff <= RF_RESET;
        end else begin
            if (wrEn) begin
                rf_ff[wrAddr] <= wrData;
            end
            rdData_ff <= rf_ff[rdIdx];
        end
    end

    assign issueReady  = state_ff[0];     // one-hot idle bit is itself a flop
    assign opDone      = done_ff;
    assign memReq      = memReq_ff;
    assign memAddr     = memAddr_ff;
    assign baseWbValid = wbValid_ff;
    assign baseWbData  = wbData_ff;
    assign rdData      = rdData_ff;
endmodule : fpx_unit

// file: test/fpx_mem_model.sv
// memory load path model: prompt or every-other-cycle answers
module fpx_mem_model
    import fpx_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        slow,
    input  wire logic        memReq,
    input  wire logic [31:0] memAddr,
    output logic             memRvalid,
    output logic      [31:0] memRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        slowValid_ff;
    logic [31:0] lastData_ff;
    // word content names its own address, so a wrong address shows up as wrong data
    wire  [31:0] memWord = {20'h3f800, memAddr[11:0]};
    assign memRvalid = slow ? slowValid_ff : memReq;
    assign memRdata  = memRvalid ? memWord : ~lastData_ff; // idle bus never repeats the previous cycle's data
    // slow mode raises valid only on every second requested cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            slowValid_ff <= 1'b0;
            lastData_ff  <= 32'h0;
        end else begin
            slowValid_ff <= memReq && !slowValid_ff;
            lastData_ff  <= memRdata;
        end
    end
endmodule : fpx_mem_model

// file: test/fpx_unit_sva.sv
module fpx_unit_sva
    import fpx_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        issueValid,
    input wire logic        issueReady,
    input wire logic [3:0]  issueOp,
    input wire logic [31:0] baseValue,
    input wire logic        addrMode,
    input wire logic        writeBack,
    input wire logic        isDouble,
    input wire logic [5:0]  regCount,
    input wire logic        offsetAdd,
    input wire logic [7:0]  offsetWords,
    input wire logic        memReq,
    input wire logic        memRvalid,
    input wire logic [31:0] memAddr,
    input wire logic        opDone,
    input wire logic        baseWbValid,
    input wire logic [31:0] baseWbData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] startAddr_ff, wbAddr_ff, nxt_startAddr, nxt_wbAddr;
    logic [6:0]  words_ff, wordCnt_ff, nxt_words;
    logic        wbReq_ff, isLoad_ff;
    wire         take = issueValid && issueReady;
    wire         isSingle = issueOp == OP_FP_LOAD_SINGLE;
    wire  [31:0] blockBytes = {24'h0, regCount, 2'b00} << isDouble;
    wire  [31:0] offBytes = {22'h0, offsetWords, 2'b00};
    // expected addresses and word counts, worked out at the take edge
    assign nxt_wbAddr = addrMode ? baseValue - blockBytes : baseValue + blockBytes;
    assign nxt_startAddr = isSingle ? (offsetAdd ? baseValue + offBytes : baseValue - offBytes)
                                    : (addrMode ? nxt_wbAddr : baseValue);
    assign nxt_words = isSingle ? {6'h0, isDouble} + 7'h1 : {1'b0, regCount} << isDouble;
    // capture per operation; count accepted words in between
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            startAddr_ff <= 32'h0;
            wbAddr_ff    <= 32'h0;
            words_ff     <= 7'h0;
            wordCnt_ff   <= 7'h0;
            wbReq_ff     <= 1'b0;
            isLoad_ff    <= 1'b0;
        end else if (take) begin
            startAddr_ff <= nxt_startAddr;
            wbAddr_ff    <= nxt_wbAddr;
            words_ff     <= nxt_words;
            wordCnt_ff   <= 7'h0;
            wbReq_ff     <= writeBack && issueOp == OP_FP_LOAD_MULTIPLE;
            isLoad_ff    <= isSingle || issueOp == OP_FP_LOAD_MULTIPLE;
        end else if (memReq && memRvalid) begin
            wordCnt_ff <= wordCnt_ff + 7'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    chk_mov_lat: assert property (take && issueOp == OP_FP_MOVE_IMMEDIATE
        |=> opDone && issueReady)
        else $error("move immediate did not finish in one cycle");
    chk_fused_lat: assert property (take && issueOp <= OP_FUSED_NEG_MUL_SUB
        |=> !opDone ##1 opDone)
        else $error("divide or fused latency wrong");
    chk_chain_lat: assert property (take
        && (issueOp == OP_CHAINED_MUL_ACC || issueOp == OP_CHAINED_MUL_SUB)
        |=> !opDone [*2] ##1 opDone)
        else $error("chained latency wrong");
    chk_start_addr: assert property (take
        && (isSingle || issueOp == OP_FP_LOAD_MULTIPLE)
        |=> memReq && memAddr == startAddr_ff)
        else $error("first load address wrong");
    chk_addr_step: assert property (memReq && memRvalid ##1 memReq
        |-> memAddr == $past(memAddr) + WORD_BYTES)
        else $error("load addresses not consecutive");
    chk_word_count: assert property (opDone && isLoad_ff
        |-> wordCnt_ff == words_ff && !memReq)
        else $error("load word count wrong");
    chk_wb_match: assert property (opDone |-> baseWbValid == wbReq_ff
        && (!baseWbValid || baseWbData == wbAddr_ff))
        else $error("base writeback wrong");
    chk_wb_pulse: assert property (baseWbValid |-> opDone ##1 !baseWbValid)
        else $error("writeback pulse not single and aligned");
endmodule : fpx_unit_sva

bind fpx_unit fpx_unit_sva fpx_unit_sva_inst (.mclk, .rstn, .issueValid, .issueReady, .issueOp,
    .baseValue, .addrMode, .writeBack, .isDouble, .regCount, .offsetAdd, .offsetWords, .memReq,
    .memRvalid, .memAddr, .opDone, .baseWbValid, .baseWbData);

// file: test/tb_fp_divide_fma_load_move_unit.sv
module tb_fp_divide_fma_load_move_unit
    import fpx_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rstn, issueValid, destOmitted, addrMode, writeBack, isDouble, offsetAdd, slow;
    logic        memRvalid, issueReady, opDone, memReq, baseWbValid, wbSeen;
    logic [3:0]  issueOp;
    logic [4:0]  destIdx, firstIdx, secondIdx, rdIdx;
    logic [7:0]  fpImm, offsetWords;
    logic [5:0]  regCount;
    logic [31:0] baseValue, memRdata, memAddr, baseWbData, rdData, wbData;
    int          errTotal = 0;
    int          numChecks = 0;
    always #2.5 mclk = ~mclk;
    fpx_unit fpx_unit_inst (.mclk, .rstn, .issueValid, .issueOp, .destIdx, .destOmitted, .firstIdx,
        .secondIdx, .fpImm, .baseValue, .addrMode, .writeBack, .isDouble, .regCount, .offsetAdd,
        .offsetWords, .memRdata, .memRvalid, .rdIdx, .issueReady, .opDone, .memReq, .memAddr,
        .baseWbValid, .baseWbData, .rdData);
    fpx_mem_model fpx_mem_model_inst (.mclk, .rstn, .slow, .memReq, .memAddr, .memRvalid, .memRdata);
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : printVerdict
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // one issue, held a single edge since the unit is idle; bounded wait for done
    task automatic run(input logic [3:0] op, input logic [4:0] dst, input logic [4:0] fst,
                       input logic [4:0] snd, input logic [7:0] imm);
        int n;
        @(posedge mclk);
        issueOp    <= op;
        destIdx    <= dst;
        firstIdx   <= fst;
        secondIdx  <= snd;
        fpImm      <= imm;
        issueValid <= 1'b1;
        @(posedge mclk);
        issueValid <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (opDone !== 1'b1 && n < 200);
        if (opDone !== 1'b1) begin
            errTotal++;
            printVerdict();
        end
        wbSeen = baseWbValid;
        wbData = baseWbData;
    endtask : run
    task automatic rd(input logic [4:0] idx, input logic [31:0] exp);
        @(posedge mclk);
        rdIdx <= idx;
        @(posedge mclk);
        @(negedge mclk);
        cmp($sformatf("S%0d", idx), exp, rdData);
    endtask : rd
    // fl bits: mode, writeback, double, offset add, slow memory
    task automatic load(input logic [3:0] op, input logic [31:0] base, input logic [4:0] fl,
                        input logic [5:0] cnt, input logic [7:0] off, input logic [4:0] dst);
        @(posedge mclk);
        baseValue   <= base;
        addrMode    <= fl[0];
        writeBack   <= fl[1];
        isDouble    <= fl[2];
        offsetAdd   <= fl[3];
        slow        <= fl[4];
        regCount    <= cnt;
        offsetWords <= off;
        run(op, dst, 5'h0, 5'h0, 8'h0);
    endtask : load
    task automatic sc_move;
        run(OP_FP_MOVE_IMMEDIATE, 5'h1, 5'h0, 5'h0, 8'h00);
        run(OP_FP_MOVE_IMMEDIATE, 5'h2, 5'h0, 5'h0, 8'h20);
        run(OP_FP_MOVE_IMMEDIATE, 5'h3, 5'h0, 5'h0, 8'h70);
        run(OP_FP_MOVE_IMMEDIATE, 5'h7, 5'h0, 5'h0, 8'hf0);
        rd(5'h1, 32'h40000000);
        rd(5'h2, 32'h41000000);
        rd(5'h3, FP_ONE);
        rd(5'h7, 32'hbf800000);
    endtask : sc_move
    // every arithmetic code with first 2.0, second 8.0, destination 1.0
    task automatic sc_arith;
        logic [31:0] exp [7] = '{32'h3e800000, 32'h41880000, 32'hc1700000, 32'hc1880000,
                                 32'h41700000, 32'h41880000, 32'hc1700000};
        for (int i = 0; i < 7; i++) begin
            run(OP_FP_MOVE_IMMEDIATE, 5'h4, 5'h0, 5'h0, 8'h70);
            run(4'(i), 5'h4, 5'h1, 5'h2, 8'h0);
            rd(5'h4, exp[i]);
        end
    endtask : sc_arith
    // operand 1+2^-12 squared: single rounding and rounded product differ
    task automatic sc_round;
        load(OP_FP_LOAD_SINGLE, 32'h900, 5'h00, 6'h0, 8'h40, 5'h5);
        rd(5'h5, 32'h3f800800);
        run(OP_FP_MOVE_IMMEDIATE, 5'h6, 5'h0, 5'h0, 8'h70);
        run(OP_FUSED_MUL_SUB, 5'h6, 5'h5, 5'h5, 8'h0);
        rd(5'h6, 32'hba000400);
        run(OP_FP_MOVE_IMMEDIATE, 5'h6, 5'h0, 5'h0, 8'h70);
        run(OP_CHAINED_MUL_SUB, 5'h6, 5'h5, 5'h5, 8'h0);
        rd(5'h6, 32'hba000000);
    endtask : sc_round
    task automatic sc_omit;
        @(posedge mclk);
        destOmitted <= 1'b1;
        run(OP_FP_DIVIDE, 5'h9, 5'h2, 5'h1, 8'h0);
        @(posedge mclk);
        destOmitted <= 1'b0;
        rd(5'h2, 32'h40800000);
        rd(5'h9, 32'h0);
    endtask : sc_omit
    // block loads: both modes, writeback on and off, slow memory, list of 16 doubles
    task automatic sc_loads;
        load(OP_FP_LOAD_MULTIPLE, 32'h100, 5'h00, 6'h3, 8'h0, 5'h8);
        cmp("baseWbValid", 32'h0, {31'h0, wbSeen});
        for (int i = 0; i < 3; i++) rd(5'(8 + i), 32'h3f800100 + 32'(4 * i));
        load(OP_FP_LOAD_MULTIPLE, 32'h200, 5'h17, 6'h2, 8'h0, 5'h6);
        cmp("baseWbData", 32'h1f0, wbData);
        for (int i = 0; i < 4; i++) rd(5'(12 + i), 32'h3f8001f0 + 32'(4 * i));
        load(OP_FP_LOAD_SINGLE, 32'h0, 5'h1c, 6'h0, 8'hff, 5'ha);
        rd(5'h14, 32'h3f8003fc);
        rd(5'h15, 32'h3f800400);
        load(OP_FP_LOAD_MULTIPLE, 32'h400, 5'h06, 6'h10, 8'h0, 5'h0);
        cmp("baseWbData", 32'h480, wbData);
        rd(5'h0, 32'h3f800400);
        rd(5'h1f, 32'h3f80047c);
    endtask : sc_loads
    initial begin
        {rstn, issueValid, destOmitted, addrMode, writeBack, isDouble, offsetAdd, slow} = 8'h0;
        {issueOp, destIdx, firstIdx, secondIdx, rdIdx, fpImm, offsetWords, regCount} = 46'h0;
        baseValue = 32'h0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        sc_move();
        sc_arith();
        sc_round();
        sc_omit();
        sc_loads();
        printVerdict();
    end
endmodule : tb_fp_divide_fma_load_move_unit
